// file: logic/ougrd_cfg.svh
// Purpose: Constants for the global register and channel decode block
// Assumes: Included by the package and the design module
// Notes: Offsets are 4-bit channel register selects or global selects
`ifndef OUGRD_CFG_SVH
`define OUGRD_CFG_SVH
`define OUGRD_NUM_CH 8
`define OUGRD_OFF_HOLD 4'h0
`define OUGRD_OFF_IEN 4'h1
`define OUGRD_OFF_ISTAT 4'h2
`define OUGRD_OFF_LCTL 4'h3
`define OUGRD_OFF_MCTL 4'h4
`define OUGRD_OFF_LSTAT 4'h5
`define OUGRD_OFF_MSTAT 4'h6
`define OUGRD_OFF_SPAD 4'h7
`define OUGRD_OFF_FEAT 4'h8
`define OUGRD_OFF_ENH 4'h9
`define OUGRD_OFF_RSV_A 4'hA
`define OUGRD_OFF_RSV_B 4'hB
`define OUGRD_OFF_XOFF1 4'hC
`define OUGRD_OFF_XOFF2 4'hD
`define OUGRD_OFF_XON1 4'hE
`define OUGRD_OFF_XON2 4'hF
`define OUGRD_G_SLEEP 4'hB
`define OUGRD_G_ID 4'hC
`define OUGRD_G_REV 4'hD
`define OUGRD_G_BCAST 4'hE
`define OUGRD_SLEEP_RST 8'h00
`define OUGRD_BCAST_RST 8'h00
`define OUGRD_BCAST_BIT 0
`define OUGRD_DLAB_BIT 7
`define OUGRD_FRAC_MASK 8'h0F
`define OUGRD_ZERO 8'h00
`define OUGRD_WAKE_CYC 6'd32
`endif

// file: logic/ougrd_pkg.sv
// Purpose: Types for the global register and channel decode block
// Assumes: ougrd_cfg.svh holds the numeric constants
// Notes: Oscillator state machine encoding lives here
`include "ougrd_cfg.svh"
package ougrd_pkg;
  typedef enum logic [1:0] {
    OUGRD_RUN = 2'b00,
    OUGRD_STOPPED = 2'b01,
    OUGRD_WAKING = 2'b10
  } ougrd_osc_t;
  typedef logic [7:0] ougrd_byte_t;
endpackage

// file: logic/ougrd_top.sv
// Purpose: Global sleep, identity and broadcast registers plus channel register decode
// Assumes: Host bus already turned into one-cycle rd_stb/wr_stb with addr and wdata
// Notes: Channel register storage beyond the holding and FIFO control paths is kept here per channel
`timescale 1ns/100ps
`include "ougrd_cfg.svh"
module ougrd_top
  import ougrd_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'hA5, // Arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h01 // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [7:0] ch_irq_pending_unused_n,
  input wire logic [7:0] ch_irq_pending,
  input wire logic [7:0] ch_rx_byte,
  input wire logic [7:0] ch_modem_change,
  input wire logic [63:0] ch_rx_holding,
  input wire logic [63:0] ch_interrupt_status,
  input wire logic [63:0] ch_line_status,
  input wire logic [63:0] ch_modem_status,
  input wire logic [63:0] ch_flow_flags,
  output logic [7:0] tx_holding_wr,
  output logic [7:0] fifo_control_wr,
  output logic [7:0] status_rd,
  output logic [7:0] wr_data_out,
  output logic [7:0] ch_asleep,
  output logic osc_enable,
  output logic ready,
  output logic wake_irq
);
  logic [7:0] divisor_low [8];
  logic [7:0] divisor_high [8];
  logic [7:0] divisor_fraction [8];
  logic [7:0] interrupt_enable [8];
  logic [7:0] line_control [8];
  logic [7:0] modem_control [8];
  logic [7:0] scratch_pad [8];
  logic [7:0] rs485_turnaround_delay [8];
  logic [7:0] feature_control [8];
  logic [7:0] enhanced_function [8];
  logic [7:0] stop_flow_char_1 [8];
  logic [7:0] stop_flow_char_2 [8];
  logic [7:0] resume_flow_char_1 [8];
  logic [7:0] resume_flow_char_2 [8];
  logic [7:0] sleep_enable;
  logic [7:0] broadcast_write_control;
  ougrd_osc_t osc_state;
  logic [5:0] wake_cnt;
  logic is_global;
  logic [2:0] ch_sel;
  logic [3:0] reg_sel;
  logic [7:0] wr_ch_mask;
  logic dlab_sel;
  logic [7:0] next_rdata;

  function automatic logic [7:0] ougrd_pick(input logic [63:0] bus, input logic [2:0] ch);
    ougrd_pick = bus[ch*8 +: 8];
  endfunction

  assign is_global = addr[7];
  assign ch_sel = addr[6:4];
  assign reg_sel = addr[3:0];
  assign dlab_sel = line_control[ch_sel][`OUGRD_DLAB_BIT];
  // Broadcast widens only the write mask; reads use ch_sel alone
  assign wr_ch_mask = broadcast_write_control[`OUGRD_BCAST_BIT] ?
    8'hFF : (8'h01 << ch_sel);

  // Global registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sleep_enable <= `OUGRD_SLEEP_RST;
      broadcast_write_control <= `OUGRD_BCAST_RST;
    end else if (wr_stb && is_global) begin
      if (reg_sel == `OUGRD_G_SLEEP) begin
        sleep_enable <= wdata;
      end
      if (reg_sel == `OUGRD_G_BCAST) begin
        broadcast_write_control <= {7'h00, wdata[`OUGRD_BCAST_BIT]};
      end
    end
  end

  // Channel configuration storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < `OUGRD_NUM_CH; i++) begin
        divisor_low[i] <= `OUGRD_ZERO;
        divisor_high[i] <= `OUGRD_ZERO;
        divisor_fraction[i] <= `OUGRD_ZERO;
        interrupt_enable[i] <= `OUGRD_ZERO;
        line_control[i] <= `OUGRD_ZERO;
        modem_control[i] <= `OUGRD_ZERO;
        scratch_pad[i] <= `OUGRD_ZERO;
        rs485_turnaround_delay[i] <= `OUGRD_ZERO;
        feature_control[i] <= `OUGRD_ZERO;
        enhanced_function[i] <= `OUGRD_ZERO;
        stop_flow_char_1[i] <= `OUGRD_ZERO;
        stop_flow_char_2[i] <= `OUGRD_ZERO;
        resume_flow_char_1[i] <= `OUGRD_ZERO;
        resume_flow_char_2[i] <= `OUGRD_ZERO;
      end
    end else if (wr_stb && !is_global) begin
      for (int i = 0; i < `OUGRD_NUM_CH; i++) begin
        if (wr_ch_mask[i]) begin
          unique case (reg_sel)
            `OUGRD_OFF_HOLD: begin
              // Holding writes leave as a strobe; only the divisor is stored
              if (dlab_sel) begin
                divisor_low[i] <= wdata;
              end
            end
            `OUGRD_OFF_IEN: begin
              if (dlab_sel) begin
                divisor_high[i] <= wdata;
              end else begin
                interrupt_enable[i] <= wdata;
              end
            end
            `OUGRD_OFF_ISTAT: begin
              // FIFO control leaves as a strobe; only the fraction is stored
              if (dlab_sel) begin
                divisor_fraction[i] <= wdata & `OUGRD_FRAC_MASK;
              end
            end
            `OUGRD_OFF_LCTL: begin
              line_control[i] <= wdata;
            end
            `OUGRD_OFF_MCTL: begin
              modem_control[i] <= wdata;
            end
            `OUGRD_OFF_MSTAT: begin
              rs485_turnaround_delay[i] <= wdata;
            end
            `OUGRD_OFF_SPAD: begin
              scratch_pad[i] <= wdata;
            end
            `OUGRD_OFF_FEAT: begin
              feature_control[i] <= wdata;
            end
            `OUGRD_OFF_ENH: begin
              enhanced_function[i] <= wdata;
            end
            `OUGRD_OFF_XOFF1: begin
              stop_flow_char_1[i] <= wdata;
            end
            `OUGRD_OFF_XOFF2: begin
              stop_flow_char_2[i] <= wdata;
            end
            `OUGRD_OFF_XON1: begin
              resume_flow_char_1[i] <= wdata;
            end
            `OUGRD_OFF_XON2: begin
              resume_flow_char_2[i] <= wdata;
            end
            default: begin
              // Line status and reserved slots ignore writes
            end
          endcase
        end
      end
    end
  end

  // Write strobes to per-channel holding and FIFO logic
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_holding_wr <= 8'h00;
      fifo_control_wr <= 8'h00;
      wr_data_out <= 8'h00;
    end else begin
      tx_holding_wr <= 8'h00;
      fifo_control_wr <= 8'h00;
      if (wr_stb && !is_global && !dlab_sel) begin
        if (reg_sel == `OUGRD_OFF_HOLD) begin
          tx_holding_wr <= wr_ch_mask;
        end
        if (reg_sel == `OUGRD_OFF_ISTAT) begin
          fifo_control_wr <= wr_ch_mask;
        end
      end
      if (wr_stb) begin
        wr_data_out <= wdata;
      end
    end
  end

  // Read mux, always the addressed channel
  always_comb begin
    next_rdata = `OUGRD_ZERO;
    if (is_global) begin
      unique case (reg_sel)
        `OUGRD_G_SLEEP: begin
          next_rdata = sleep_enable;
        end
        `OUGRD_G_ID: begin
          next_rdata = PART_ID;
        end
        `OUGRD_G_REV: begin
          next_rdata = SILICON_REV;
        end
        `OUGRD_G_BCAST: begin
          next_rdata = broadcast_write_control;
        end
        default: next_rdata = `OUGRD_ZERO;
      endcase
    end else begin
      unique case (reg_sel)
        `OUGRD_OFF_HOLD: next_rdata = dlab_sel ? divisor_low[ch_sel] :
          ougrd_pick(ch_rx_holding, ch_sel);
        `OUGRD_OFF_IEN: next_rdata = dlab_sel ? divisor_high[ch_sel] :
          interrupt_enable[ch_sel];
        `OUGRD_OFF_ISTAT: next_rdata = dlab_sel ? divisor_fraction[ch_sel] :
          (wake_irq ? `OUGRD_ZERO : ougrd_pick(ch_interrupt_status, ch_sel));
        `OUGRD_OFF_LCTL: begin
          next_rdata = line_control[ch_sel];
        end
        `OUGRD_OFF_MCTL: begin
          next_rdata = modem_control[ch_sel];
        end
        `OUGRD_OFF_LSTAT: begin
          next_rdata = ougrd_pick(ch_line_status, ch_sel);
        end
        `OUGRD_OFF_MSTAT: begin
          next_rdata = ougrd_pick(ch_modem_status, ch_sel);
        end
        `OUGRD_OFF_SPAD: begin
          next_rdata = scratch_pad[ch_sel];
        end
        `OUGRD_OFF_FEAT: begin
          next_rdata = feature_control[ch_sel];
        end
        `OUGRD_OFF_ENH: begin
          next_rdata = enhanced_function[ch_sel];
        end
        `OUGRD_OFF_XOFF1: begin
          next_rdata = ougrd_pick(ch_flow_flags, ch_sel);
        end
        default: next_rdata = `OUGRD_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata <= `OUGRD_ZERO;
      status_rd <= 8'h00;
    end else begin
      status_rd <= 8'h00;
      if (rd_stb) begin
        rdata <= next_rdata;
        if (!is_global && !dlab_sel && reg_sel == `OUGRD_OFF_ISTAT) begin
          status_rd <= 8'h01 << ch_sel;
        end
      end
    end
  end

  // Per-channel sleep gating
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ch_asleep <= 8'h00;
    end else begin
      ch_asleep <= sleep_enable & ~ch_irq_pending;
    end
  end
  assign ch_irq_pending_unused_n = ~ch_irq_pending;

  // Oscillator control and wake sequence
  always_ff @(posedge core_clk) begin
    if (srst) begin
      osc_state <= OUGRD_RUN;
      wake_cnt <= 6'd0;
      osc_enable <= 1'b1;
      ready <= 1'b1;
    end else begin
      unique case (osc_state)
        OUGRD_RUN: begin
          if (&ch_asleep) begin
            osc_state <= OUGRD_STOPPED;
            osc_enable <= 1'b0;
            ready <= 1'b0;
          end
        end
        OUGRD_STOPPED: begin
          if (|(ch_rx_byte | ch_modem_change)) begin
            osc_state <= OUGRD_WAKING;
            osc_enable <= 1'b1;
            wake_cnt <= 6'd0;
          end
        end
        OUGRD_WAKING: begin
          wake_cnt <= wake_cnt + 6'd1;
          if (wake_cnt == `OUGRD_WAKE_CYC - 6'd1) begin
            osc_state <= OUGRD_RUN;
            ready <= 1'b1;
          end
        end
        default: osc_state <= OUGRD_RUN;
      endcase
    end
  end

  // Special wake interrupt, cleared by a status read; new wake wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_irq <= 1'b0;
    end else if (osc_state == OUGRD_WAKING && wake_cnt == `OUGRD_WAKE_CYC - 6'd1) begin
      wake_irq <= 1'b1;
    end else if (|status_rd) begin
      wake_irq <= 1'b0;
    end
  end
endmodule // ougrd_top

// file: test/ougrd_top_assertions.sv
// Purpose: Port-level checks of the global register and channel decode block
// Assumes: Bound to ougrd_top, one clock domain
// Notes: Wake delay is measured from osc_enable rising
`timescale 1ns/100ps
module ougrd_top_assertions (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] ch_irq_pending,
  input wire logic [7:0] ch_rx_byte,
  input wire logic [7:0] ch_modem_change,
  input wire logic [7:0] tx_holding_wr,
  input wire logic [7:0] status_rd,
  input wire logic [7:0] wr_data_out,
  input wire logic [7:0] ch_asleep,
  input wire logic osc_enable,
  input wire logic ready,
  input wire logic wake_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence wake_wait_seq;
    ##28 !ready ##[1:6] ready;
  endsequence
  chk_rdata_hold: assert property (!rd_stb |=> $stable(rdata))
    else $error("rdata changed without a read");
  chk_sleep_gate: assert property (1 |=> (ch_asleep & $past(ch_irq_pending)) == 8'h00)
    else $error("channel asleep with interrupt pending");
  chk_osc_stop: assert property (ch_asleep == 8'hFF && osc_enable && ready && ch_rx_byte == 8'h00
    && ch_modem_change == 8'h00 |=> !osc_enable) else $error("oscillator kept running");
  chk_osc_wake: assert property (!osc_enable && (ch_rx_byte | ch_modem_change) != 8'h00
    |=> osc_enable) else $error("no wake on channel event");
  chk_ready_delay: assert property ($rose(osc_enable) |-> wake_wait_seq)
    else $error("ready not after wake delay");
  chk_wake_irq_set: assert property ($rose(ready) |-> wake_irq)
    else $error("wake interrupt missing");
  chk_wake_status: assert property (rd_stb && wake_irq && !addr[7] && addr[3:0] == 4'h2
    |=> status_rd == 8'h00 || rdata == 8'h00) else $error("wake status not empty");
  chk_pulse_idle: assert property (!wr_stb |=> tx_holding_wr == 8'h00)
    else $error("holding write pulse without write");
  chk_read_single: assert property (rd_stb |=> $onehot0(status_rd))
    else $error("status read reached several channels");
  chk_wdata_copy: assert property (wr_stb |=> wr_data_out == $past(wdata))
    else $error("write data not passed on");
  chk_rsvd_zero: assert property (rd_stb && !addr[7] && addr[3:1] == 3'h5 |=> rdata == 8'h00)
    else $error("reserved offset read nonzero");
endmodule // ougrd_top_assertions
bind ougrd_top ougrd_top_assertions u_chk (.core_clk, .srst, .addr, .rd_stb, .wr_stb, .wdata,
  .rdata, .ch_irq_pending, .ch_rx_byte, .ch_modem_change, .tx_holding_wr, .status_rd,
  .wr_data_out, .ch_asleep, .osc_enable, .ready, .wake_irq);

// file: test/ougrd_chan_model.sv
// Purpose: Channel-side model feeding per-channel status bytes
// Assumes: Each byte is a fixed code plus the channel number
// Notes: Distinct per channel so a wrong channel select shows
`timescale 1ns/100ps
module ougrd_chan_model (
  output logic [63:0] ch_rx_holding,
  output logic [63:0] ch_interrupt_status,
  output logic [63:0] ch_line_status,
  output logic [63:0] ch_modem_status,
  output logic [63:0] ch_flow_flags
);
  for (genvar i = 0; i < 8; i++) begin : g_ch
    assign ch_rx_holding[8*i+:8] = 8'h10 + 8'(i);
    assign ch_interrupt_status[8*i+:8] = 8'h20 + 8'(i);
    assign ch_line_status[8*i+:8] = 8'h30 + 8'(i);
    assign ch_modem_status[8*i+:8] = 8'h40 + 8'(i);
    assign ch_flow_flags[8*i+:8] = 8'h50 + 8'(i);
  end
endmodule // ougrd_chan_model

// file: test/octal_uart_global_regs_decode_tb_top.sv
// Purpose: Self-checking bench for the global register and channel decode block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Each bus operation takes two cycles
`timescale 1ns/100ps
module octal_uart_global_regs_decode_tb_top;
  import ougrd_pkg::*;
  localparam logic [7:0] ID_EXP = 8'hA5; // Arbitrary value
  localparam logic [7:0] REV_EXP = 8'h3C; // Arbitrary value
  logic core_clk, srst, rd_stb, wr_stb, osc_enable, ready, wake_irq;
  logic [7:0] addr, wdata, rdata, ch_irq_pending, ch_rx_byte, ch_modem_change;
  logic [7:0] tx_holding_wr, fifo_control_wr, status_rd, wr_data_out, ch_asleep;
  logic [63:0] ch_rx_holding, ch_interrupt_status, ch_line_status, ch_modem_status, ch_flow_flags;
  int fail_count = 0;
  int num_checks = 0;
  ougrd_chan_model u_model (.ch_rx_holding, .ch_interrupt_status, .ch_line_status,
    .ch_modem_status, .ch_flow_flags);
  ougrd_top #(.PART_ID(ID_EXP), .SILICON_REV(REV_EXP)) uut (.core_clk, .srst, .addr, .rd_stb,
    .wr_stb, .wdata, .rdata, .ch_irq_pending_unused_n(), .ch_irq_pending, .ch_rx_byte,
    .ch_modem_change, .ch_rx_holding, .ch_interrupt_status, .ch_line_status, .ch_modem_status,
    .ch_flow_flags, .tx_holding_wr, .fifo_control_wr, .status_rd, .wr_data_out, .ch_asleep,
    .osc_enable, .ready, .wake_irq);
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic compare(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 addr = a;
    wdata = d;
    wr_stb = 1'h1;
    @(posedge core_clk);
    #1 wr_stb = 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1 addr = a;
    rd_stb = 1'h1;
    @(posedge core_clk);
    #1 rd_stb = 1'h0;
    compare("rdata", rdata, exp);
  endtask
  task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    wr(a, d);
    rdc(a, exp);
  endtask
  task automatic t_global();
    rdc(8'h8B, 8'h00);
    rdc(8'h8C, ID_EXP);
    rdc(8'h8D, REV_EXP);
    rdc(8'h8E, 8'h00);
    rdc(8'h80, 8'h00);
    $display("test global done");
  endtask
  task automatic t_map();
    rdc(8'h30, 8'h13);
    rdc(8'h32, 8'h23);
    compare("status_rd", status_rd, 8'h08);
    wrd(8'h35, 8'h00, 8'h33);
    rdc(8'h36, 8'h43);
    wrd(8'h3C, 8'h11, 8'h53);
    wrd(8'h3E, 8'h22, 8'h00);
    wrd(8'h3A, 8'hFF, 8'h00);
    wrd(8'h31, 8'h0F, 8'h0F);
    wrd(8'h34, 8'h0B, 8'h0B);
    wrd(8'h37, 8'h5A, 8'h5A);
    wrd(8'h38, 8'h30, 8'h30);
    wrd(8'h39, 8'hC0, 8'hC0);
    wr(8'h32, 8'h07);
    compare("fifo_control_wr", fifo_control_wr, 8'h08);
    wrd(8'h33, 8'h83, 8'h83);
    wr(8'h30, 8'h11);
    compare("tx_holding_wr", tx_holding_wr, 8'h00);
    rdc(8'h30, 8'h11);
    wrd(8'h31, 8'h22, 8'h22);
    wrd(8'h32, 8'hFF, 8'h0F);
    wr(8'h33, 8'h03);
    rdc(8'h31, 8'h0F);
    $display("test map done");
  endtask
  task automatic t_bcast();
    wrd(8'h8E, 8'hFF, 8'h01);
    wr(8'h07, 8'hC3);
    wr(8'h00, 8'h5E);
    compare("tx_holding_wr", tx_holding_wr, 8'hFF);
    wrd(8'h8E, 8'h00, 8'h00);
    rdc(8'h57, 8'hC3);
    wr(8'h50, 8'h01);
    compare("tx_holding_wr", tx_holding_wr, 8'h20);
    compare("wr_data_out", wr_data_out, 8'h01);
    $display("test broadcast done");
  endtask
  task automatic t_sleep();
    int n;
    ch_irq_pending = 8'h04;
    wrd(8'h8B, 8'hFF, 8'hFF);
    compare("ch_asleep", ch_asleep, 8'hFB);
    ch_irq_pending = 8'h00;
    repeat (3) @(posedge core_clk);
    #1 compare("osc_enable", {7'h00, osc_enable}, 8'h00);
    ch_rx_byte = 8'h10;
    ch_irq_pending = 8'h10;
    @(posedge core_clk);
    #1 ch_rx_byte = 8'h00;
    n = 0;
    while (ready !== 1'h1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    compare("wake", {5'h00, osc_enable, ready, wake_irq}, 8'h07);
    rdc(8'h02, 8'h00);
    @(posedge core_clk);
    #1 compare("wake_irq", {7'h00, wake_irq}, 8'h00);
    ch_irq_pending = 8'h00;
    repeat (3) @(posedge core_clk);
    #1 compare("osc_enable", {7'h00, osc_enable}, 8'h00);
    ch_modem_change = 8'h01;
    ch_irq_pending = 8'h01;
    @(posedge core_clk);
    #1 ch_modem_change = 8'h00;
    repeat (32) @(posedge core_clk);
    #1 compare("modem wake", {6'h00, osc_enable, ready}, 8'h03);
    wr(8'h8B, 8'h00);
    $display("test sleep done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
  initial begin
    {srst, rd_stb, wr_stb} = 3'h4;
    {addr, wdata, ch_irq_pending, ch_rx_byte, ch_modem_change} = 40'h00;
    repeat (5) @(posedge core_clk);
    #1 srst = 1'h0;
    t_global();
    t_map();
    t_bcast();
    t_sleep();
    end_of_test();
  end
endmodule // octal_uart_global_regs_decode_tb_top
